// File: verilog/seq_pkg.sv
// Shared constants for the dual PLL power-up sequencer
`default_nettype none
package seq_pkg;
    // Clock and internal oscillator rates
    localparam int CLK_HZ       = 25_000_000;
    localparam int OSC_HZ       = 10_000_000;
    localparam int OSC_PER_NS   = 1_000_000_000 / OSC_HZ;
    // Oscillator tick accumulator: STEP ticks per MOD clocks
    localparam logic [4:0] ACC_STEP = 5'(OSC_HZ / 1_000_000);
    localparam logic [4:0] ACC_MOD  = 5'(CLK_HZ / 1_000_000);

    // Step counters must hold 300 ms of oscillator cycles
    localparam int CNT_W        = 22;
    localparam int CAL_MAX_NS   = 300_000_000;
    localparam int CNT_MIN_W    = $clog2(CAL_MAX_NS / OSC_PER_NS + 1);
    // Default step durations loaded at power-on
    localparam int CAL_DEF_NS   = 300_000;
    localparam int VCO_DEF_NS   = 400_000;
    localparam logic [CNT_W-1:0] CAL_DEF_CYC = CNT_W'(CAL_DEF_NS / OSC_PER_NS);
    localparam logic [CNT_W-1:0] VCO_DEF_CYC = CNT_W'(VCO_DEF_NS / OSC_PER_NS);

    // Register byte offsets
    localparam logic [4:0] REG_CTRL     = 5'h00;
    localparam logic [4:0] REG_STATE    = 5'h04;
    localparam logic [4:0] REG_A_CAL    = 5'h08;
    localparam logic [4:0] REG_A_VCO    = 5'h0C;
    localparam logic [4:0] REG_B_CAL    = 5'h10;
    localparam logic [4:0] REG_B_VCO    = 5'h14;
    localparam logic [4:0] REG_INT_STAT = 5'h18;
    localparam logic [4:0] REG_INT_MASK = 5'h1C;

    // Control register fields
    localparam int CTRL_W       = 4;
    localparam int CTRL_XTAL    = 0;
    localparam int CTRL_INDEP   = 1;
    localparam int CTRL_STA_SEL = 2;
    localparam int CTRL_STB_SEL = 3;
    localparam logic [CTRL_W-1:0] CTRL_SEL_DEF = 4'h8;

    // Interrupt event bits
    localparam int INT_W        = 4;
    localparam int INT_A_LOCK   = 0;
    localparam int INT_B_LOCK   = 1;
    localparam int INT_PDN      = 2;
    localparam int INT_XTAL     = 3;
endpackage : seq_pkg
`default_nettype wire

// File: verilog/pll_step_if.sv
// Control and status bundle between the sequencer and one PLL step unit
`timescale 1ns/1ps
`default_nettype none
interface pll_step_if #(parameter int CNT_W = seq_pkg::CNT_W);
    logic             clear;
    logic             start;
    logic             tick;
    logic [CNT_W-1:0] cal_count;
    logic [CNT_W-1:0] vco_count;
    logic             lock;
    logic             pfd_tick;
    logic             cal_active;
    logic             out_en;
    logic             lock_lost_flag;
    logic             done;
    logic             lock_ev;

    modport ctrl (output clear, start, tick, cal_count, vco_count, lock, pfd_tick,
                  input cal_active, out_en, lock_lost_flag, done, lock_ev);
    modport unit (input clear, start, tick, cal_count, vco_count, lock, pfd_tick,
                  output cal_active, out_en, lock_lost_flag, done, lock_ev);
endinterface : pll_step_if
`default_nettype wire

// File: verilog/osc_tick_gen.sv
// Internal oscillator tick derived from the system clock
`timescale 1ns/1ps
`default_nettype none
module osc_tick_gen #(
    parameter logic [4:0] STEP = seq_pkg::ACC_STEP,
    parameter logic [4:0] MOD  = seq_pkg::ACC_MOD
) (
    input  wire logic clk_i,
    input  wire logic srst_i,
    output logic      tick_o
);
    logic [4:0] acc;
    logic [4:0] next_acc;
    logic [5:0] sum;
    logic       next_tick;

    if (STEP == 5'h00 || STEP >= MOD) begin : g_bad_ratio
        $error("osc_tick_gen: STEP must lie between 1 and MOD-1");
    end

    // Fractional accumulator gives STEP ticks every MOD clocks
    always_comb begin
        sum       = {1'b0, acc} + {1'b0, STEP};
        next_tick = (sum >= {1'b0, MOD});
        next_acc  = next_tick ? 5'(sum - {1'b0, MOD}) : sum[4:0];
    end

    // Registers
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            acc    <= 5'h00;
            tick_o <= 1'b0;
        end else begin
            acc    <= next_acc;
            tick_o <= next_tick;
        end
    end
endmodule : osc_tick_gen
`default_nettype wire

// File: verilog/pll_step_unit.sv
// Calibration, VCO wait and lock steps of one PLL
`timescale 1ns/1ps
`default_nettype none
module pll_step_unit #(
    parameter int CNT_W = seq_pkg::CNT_W
) (
    input  wire logic clk_i,
    input  wire logic srst_i,
    pll_step_if.unit  step
);
    typedef enum logic [4:0] {
        U_IDLE = 5'b00001,
        U_CAL  = 5'b00010,
        U_VCO  = 5'b00100,
        U_LOCK = 5'b01000,
        U_DONE = 5'b10000
    } unit_state_e;

    unit_state_e      state;
    unit_state_e      next_state;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;
    logic             lock_lost_flag;
    logic             next_lol;

    // True on the last oscillator cycle of a step; a zero count acts as one
    function automatic logic cnt_last(input logic [CNT_W-1:0] c, input logic [CNT_W-1:0] lim);
        cnt_last = ({1'b0, c} + 1'b1) >= {1'b0, lim};
    endfunction : cnt_last

    // Step sequencing
    always_comb begin
        next_state = state;
        next_cnt   = cnt;
        next_lol   = lock_lost_flag;
        case (state)
            U_IDLE: begin
                if (step.start) begin
                    next_state = U_CAL;
                    next_cnt   = '0;
                end
            end
            U_CAL: begin
                if (step.tick) begin // see R3 R9
                    if (cnt_last(cnt, step.cal_count)) begin
                        next_state = U_VCO;
                        next_cnt   = '0;
                    end else begin
                        next_cnt = cnt + 1'b1;
                    end
                end
            end
            U_VCO: begin
                if (step.tick) begin // see R4 R9
                    if (cnt_last(cnt, step.vco_count)) begin
                        next_state = U_LOCK;
                        next_cnt   = '0;
                    end else begin
                        next_cnt = cnt + 1'b1;
                    end
                end
            end
            U_LOCK: begin
                if (step.lock && step.pfd_tick) begin // see R8 R10
                    next_state = U_DONE;
                    next_lol   = 1'b0;
                end
            end
            U_DONE: next_lol = ~step.lock;
            default: next_state = U_IDLE;
        endcase
        if (step.clear) begin // see R19
            next_state = U_IDLE;
            next_cnt   = '0;
            next_lol   = 1'b1;
        end
    end

    // Registers
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            state <= U_IDLE;
            cnt   <= '0;
            lock_lost_flag   <= 1'b1;
        end else begin
            state <= next_state;
            cnt   <= next_cnt;
            lock_lost_flag   <= next_lol;
        end
    end

    // Status towards the sequencer; outputs run before full lock
    assign step.cal_active = (state == U_CAL);
    assign step.out_en     = (state == U_LOCK) || (state == U_DONE); // see R7
    assign step.lock_lost_flag        = lock_lost_flag;
    assign step.done       = (state == U_DONE);
    assign step.lock_ev    = (state == U_LOCK) && step.lock && step.pfd_tick && !step.clear;

    a_cal_to_vco: assert property (@(posedge clk_i) disable iff (srst_i) // see R3
        state == U_CAL && step.tick && cnt_last(cnt, step.cal_count) && !step.clear
        |=> state == U_VCO && cnt == '0)
        else $error("calibration did not end at its count");
    a_vco_to_out: assert property (@(posedge clk_i) disable iff (srst_i) // see R7
        state == U_VCO && step.tick && cnt_last(cnt, step.vco_count) && !step.clear
        |=> step.out_en && !step.done)
        else $error("outputs not enabled after VCO wait");
    a_no_out_early: assert property (@(posedge clk_i) disable iff (srst_i) // see R4
        (state == U_CAL || state == U_VCO) |-> !step.out_en && step.lock_lost_flag)
        else $error("outputs on before VCO wait ended");
    a_lol_drop: assert property (@(posedge clk_i) disable iff (srst_i) // see R8
        step.lock_ev |=> !step.lock_lost_flag && step.done)
        else $error("lock flag did not fall at lock");
    a_lol_held: assert property (@(posedge clk_i) disable iff (srst_i) // see R19
        step.clear |=> step.lock_lost_flag && !step.out_en ##1 step.lock_lost_flag)
        else $error("lock flag released too early");
endmodule : pll_step_unit
`default_nettype wire

// File: verilog/dual_pll_powerup_sequencer.sv
// Power-up sequencer for a two-PLL clock generator with Avalon-MM registers
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// R1: Hold reset until supplies good, then count
// R2: With crystal, wait for amplitude detector
// R3: PLL A calibration counts oscillator ticks
// R4: PLL A VCO wait counts oscillator ticks
// R5: Software picks calibration count by bandwidth
// R6: Software sets VCO wait near 400 us
// R7: Enable outputs right after wait steps
// R8: PLL A lock flag falls one PFD cycle
// R9: PLL B has its own two counts
// R10: PLL B lock flag falls one PFD cycle
// R11: Mode 0: PLL B after PLL A locks
// R12: Mode 1: PLL B after crystal step
// R13: Power-down low disables the whole device; the design keeps irq_o, the status pins and register reads active
// R14: Power-down release reloads registers from straps
// R15: Management bus off while power-down low
// R16: Host may float or drive power-down
// R17: Prefer sequential locking with stored configuration
// R18: Longer delays suit slow reference clocks
// R19: Lock flags held until lock step done
module dual_pll_powerup_sequencer #(
    parameter int CNT_W = seq_pkg::CNT_W
) (
    input  wire logic        clk_i,
    input  wire logic        srst_i,
    input  wire logic        chip_power_down_n_i,
    input  wire logic        supply_ok_i,
    input  wire logic [1:0]  cfg_pins_i,
    input  wire logic        crystal_ok_i,
    input  wire logic        pll_a_lock_i,
    input  wire logic        pll_b_lock_i,
    input  wire logic        pfd_tick_a_i,
    input  wire logic        pfd_tick_b_i,
    output logic             out_en_a_o,
    output logic             out_en_b_o,
    output logic             status_pin_a_o,
    output logic             status_pin_b_o,
    output logic             mgmt_bus_en_o,
    output logic             irq_o,
    input  wire logic [4:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic [31:0]      avs_readdata_o,
    output logic             avs_waitrequest_o
);
    typedef enum logic [3:0] {
        S_OFF  = 4'b0001,
        S_LOAD = 4'b0010,
        S_XTAL = 4'b0100,
        S_RUN  = 4'b1000
    } seq_state_e;

    // Refuse counter widths that cannot hold the longest step
    if (CNT_W < seq_pkg::CNT_MIN_W || CNT_W > 32) begin : g_bad_width
        $error("dual_pll_powerup_sequencer: CNT_W cannot hold the longest step");
    end

    seq_state_e                      state;
    seq_state_e                      next_state;
    logic                            run_indep;
    logic                            next_run_indep;

    logic                            bus_en;
    logic                            next_bus_en;

    logic [seq_pkg::CTRL_W-1:0]      ctrl;
    logic [seq_pkg::CTRL_W-1:0]      next_ctrl;

    logic [CNT_W-1:0]                a_cal;
    logic [CNT_W-1:0]                next_a_cal;
    logic [CNT_W-1:0]                a_vco;
    logic [CNT_W-1:0]                next_a_vco;
    logic [CNT_W-1:0]                b_cal;
    logic [CNT_W-1:0]                next_b_cal;
    logic [CNT_W-1:0]                b_vco;
    logic [CNT_W-1:0]                next_b_vco;

    logic                            ack;
    logic                            next_ack;
    logic [31:0]                     rdata;
    logic [31:0]                     next_rdata;

    logic [seq_pkg::INT_W-1:0]       int_stat;
    logic [seq_pkg::INT_W-1:0]       next_int_stat;
    logic [seq_pkg::INT_W-1:0]       int_mask;
    logic [seq_pkg::INT_W-1:0]       next_int_mask;

    logic [seq_pkg::INT_W-1:0]       events;
    logic                            osc_tick;
    logic                            powered;
    logic                            req;
    logic                            acc;
    logic                            wr_ok;

    pll_step_if #(.CNT_W(CNT_W)) step_a ();
    pll_step_if #(.CNT_W(CNT_W)) step_b ();

    // Merge a write into a register under the byte enables
    function automatic logic [31:0] byte_merge(input logic [31:0] old, input logic [31:0] wd,
                                               input logic [3:0] be);
        for (int i = 0; i < 4; i++) begin
            byte_merge[i*8 +: 8] = be[i] ? wd[i*8 +: 8] : old[i*8 +: 8];
        end
    endfunction : byte_merge

    // Shared internal oscillator
    osc_tick_gen u_osc (
        .clk_i  (clk_i),
        .srst_i (srst_i),
        .tick_o (osc_tick)
    );

    // One step unit per PLL
    pll_step_unit #(.CNT_W(CNT_W)) u_pll_a (
        .clk_i  (clk_i),
        .srst_i (srst_i),
        .step   (step_a)
    );

    pll_step_unit #(.CNT_W(CNT_W)) u_pll_b (
        .clk_i  (clk_i),
        .srst_i (srst_i),
        .step   (step_b)
    );

    // Power-on reset holds while the pin is low or the supplies are short
    assign powered = chip_power_down_n_i && supply_ok_i; // see R1 R13

    // Top-level sequence
    always_comb begin
        next_state     = state;
        next_run_indep = run_indep;
        next_bus_en    = chip_power_down_n_i; // see R15
        case (state)
            S_OFF:  next_state = S_LOAD;
            S_LOAD: next_state = S_XTAL; // see R14
            S_XTAL: begin
                if (!ctrl[seq_pkg::CTRL_XTAL] || crystal_ok_i) begin // see R2
                    next_state     = S_RUN;
                    next_run_indep = ctrl[seq_pkg::CTRL_INDEP];
                end
            end
            S_RUN:  next_state = S_RUN;
            default: next_state = S_OFF;
        endcase
        // Losing the pin or a supply restarts from OFF
        if (!powered) begin // see R1 R13
            next_state = S_OFF;
        end
    end

    // Sequence state flops
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            state     <= S_OFF;
            run_indep <= 1'b0;
            bus_en    <= 1'b0;
        end else begin
            state     <= next_state;
            run_indep <= next_run_indep;
            bus_en    <= next_bus_en;
        end
    end

    // Drive both PLL units; mode bit picks serial or parallel start
    always_comb begin
        step_a.clear     = (state != S_RUN); // see R13
        step_b.clear     = (state != S_RUN);
        step_a.start     = (state == S_RUN); // see R1
        step_b.start     = (state == S_RUN) && (run_indep || step_a.done); // see R11 R12

        // Shared tick, per-PLL counts and loop inputs
        step_a.tick      = osc_tick;
        step_b.tick      = osc_tick;
        step_a.cal_count = a_cal;
        step_a.vco_count = a_vco;
        step_b.cal_count = b_cal;
        step_b.vco_count = b_vco;
        step_a.lock      = pll_a_lock_i;
        step_b.lock      = pll_b_lock_i;
        step_a.pfd_tick  = pfd_tick_a_i;
        step_b.pfd_tick  = pfd_tick_b_i;
    end

    // Pin outputs; each status pin shows the lock flag it is routed to
    assign out_en_a_o     = step_a.out_en; // see R7
    assign out_en_b_o     = step_b.out_en;
    assign status_pin_a_o = ctrl[seq_pkg::CTRL_STA_SEL] ? step_b.lock_lost_flag : step_a.lock_lost_flag; // see R8 R10
    assign status_pin_b_o = ctrl[seq_pkg::CTRL_STB_SEL] ? step_b.lock_lost_flag : step_a.lock_lost_flag;
    assign mgmt_bus_en_o  = bus_en;

    // Avalon handshake: one wait cycle, answer on the second edge
    assign req               = avs_read_i || avs_write_i;
    assign acc               = req && ack;
    assign avs_waitrequest_o = req && !ack;
    assign avs_readdata_o    = rdata;
    assign wr_ok             = acc && avs_write_i && bus_en && (state == S_XTAL || state == S_RUN);

    // Events for the interrupt status
    always_comb begin
        events                      = '0;
        events[seq_pkg::INT_A_LOCK] = step_a.lock_ev;
        events[seq_pkg::INT_B_LOCK] = step_b.lock_ev;
        events[seq_pkg::INT_PDN]    = (state != S_OFF) && (next_state == S_OFF);
        events[seq_pkg::INT_XTAL]   = (state == S_XTAL) && (next_state == S_RUN);
    end

    // Bus, configuration and interrupt registers
    always_comb begin
        next_ack      = req && !ack;
        next_rdata    = rdata;
        next_ctrl     = ctrl;
        next_a_cal    = a_cal;
        next_a_vco    = a_vco;
        next_b_cal    = b_cal;
        next_b_vco    = b_vco;
        next_int_mask = int_mask;
        next_int_stat = int_stat | events;

        // Read data captured on the wait cycle, held through the answer
        if (avs_read_i && !ack) begin
            case (avs_address_i)
                seq_pkg::REG_CTRL:     next_rdata = 32'(ctrl);
                seq_pkg::REG_STATE:    next_rdata = 32'({step_b.lock_lost_flag, step_a.lock_lost_flag, step_b.out_en, step_a.out_en,
                                                         step_b.done, step_a.done, state});
                seq_pkg::REG_A_CAL:    next_rdata = 32'(a_cal);
                seq_pkg::REG_A_VCO:    next_rdata = 32'(a_vco);
                seq_pkg::REG_B_CAL:    next_rdata = 32'(b_cal);
                seq_pkg::REG_B_VCO:    next_rdata = 32'(b_vco);
                seq_pkg::REG_INT_STAT: next_rdata = 32'(int_stat);
                seq_pkg::REG_INT_MASK: next_rdata = 32'(int_mask);
                default:               next_rdata = 32'h0000_0000;
            endcase
        end

        // Clear only the bits that were returned; a new event still wins
        if (acc && avs_read_i && avs_address_i == seq_pkg::REG_INT_STAT) begin
            next_int_stat = (int_stat & ~rdata[seq_pkg::INT_W-1:0]) | events;
        end

        // The mask stays writable in every state
        if (acc && avs_write_i && avs_address_i == seq_pkg::REG_INT_MASK) begin
            next_int_mask = seq_pkg::INT_W'(byte_merge(32'(int_mask), avs_writedata_i, avs_byteenable_i));
        end

        // Configuration writes land only once loaded and powered
        if (wr_ok) begin
            case (avs_address_i)
                seq_pkg::REG_CTRL:  next_ctrl  = seq_pkg::CTRL_W'(byte_merge(32'(ctrl), avs_writedata_i,
                                                                            avs_byteenable_i));
                seq_pkg::REG_A_CAL: next_a_cal = CNT_W'(byte_merge(32'(a_cal), avs_writedata_i, avs_byteenable_i));
                seq_pkg::REG_A_VCO: next_a_vco = CNT_W'(byte_merge(32'(a_vco), avs_writedata_i, avs_byteenable_i));
                seq_pkg::REG_B_CAL: next_b_cal = CNT_W'(byte_merge(32'(b_cal), avs_writedata_i, avs_byteenable_i));
                seq_pkg::REG_B_VCO: next_b_vco = CNT_W'(byte_merge(32'(b_vco), avs_writedata_i, avs_byteenable_i));
                default: ;
            endcase
        end

        // Power-on load: straps pick crystal use and PLL B start mode
        if (state == S_LOAD) begin // see R14
            next_ctrl                     = seq_pkg::CTRL_SEL_DEF;
            next_ctrl[seq_pkg::CTRL_XTAL] = cfg_pins_i[0];
            next_ctrl[seq_pkg::CTRL_INDEP] = cfg_pins_i[1];
            next_a_cal                    = seq_pkg::CAL_DEF_CYC;
            next_a_vco                    = seq_pkg::VCO_DEF_CYC;
            next_b_cal                    = seq_pkg::CAL_DEF_CYC;
            next_b_vco                    = seq_pkg::VCO_DEF_CYC;
        end
    end

    // Bus, configuration and interrupt flops
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            ack      <= 1'b0;
            rdata    <= 32'h0000_0000;
            ctrl     <= seq_pkg::CTRL_SEL_DEF;
            a_cal    <= seq_pkg::CAL_DEF_CYC;
            a_vco    <= seq_pkg::VCO_DEF_CYC;
            b_cal    <= seq_pkg::CAL_DEF_CYC;
            b_vco    <= seq_pkg::VCO_DEF_CYC;
            int_stat <= '0;
            int_mask <= '0;
        end else begin
            ack      <= next_ack;
            rdata    <= next_rdata;
            ctrl     <= next_ctrl;
            a_cal    <= next_a_cal;
            a_vco    <= next_a_vco;
            b_cal    <= next_b_cal;
            b_vco    <= next_b_vco;
            int_stat <= next_int_stat;
            int_mask <= next_int_mask;
        end
    end

    // Level interrupt while any unmasked status bit is set
    assign irq_o = |(int_stat & int_mask);

    // Sequencer checks
    a_off_on_pdn: assert property (@(posedge clk_i) disable iff (srst_i) // see R13
        !chip_power_down_n_i |=> state == S_OFF ##1 !out_en_a_o && !out_en_b_o)
        else $error("device still active while powered down");

    // Units are cleared one edge after the sequencer drops to OFF
    a_supply_hold: assert property (@(posedge clk_i) disable iff (srst_i) // see R1
        !supply_ok_i |=> state == S_OFF ##1 !step_a.cal_active && !step_b.cal_active)
        else $error("sequence ran without good supplies");

    a_bus_off_pdn: assert property (@(posedge clk_i) disable iff (srst_i) // see R15
        !chip_power_down_n_i |=> !mgmt_bus_en_o)
        else $error("management bus enabled while powered down");

    a_xtal_wait: assert property (@(posedge clk_i) disable iff (srst_i) // see R2
        state == S_XTAL && ctrl[seq_pkg::CTRL_XTAL] && !crystal_ok_i && powered
        |=> state == S_XTAL && !step_a.cal_active)
        else $error("lock sequence ran before crystal swing");

    a_load_straps: assert property (@(posedge clk_i) disable iff (srst_i) // see R14
        state == S_LOAD |=> ctrl[seq_pkg::CTRL_XTAL] == $past(cfg_pins_i[0])
                            && ctrl[seq_pkg::CTRL_INDEP] == $past(cfg_pins_i[1]) && a_cal == seq_pkg::CAL_DEF_CYC)
        else $error("power-on load did not follow straps");

    a_b_serial: assert property (@(posedge clk_i) disable iff (srst_i) // see R11
        state == S_RUN && !run_indep && !step_a.done |=> !step_b.cal_active && !step_b.out_en)
        else $error("PLL B started before PLL A locked");

    a_b_parallel: assert property (@(posedge clk_i) disable iff (srst_i) // see R12
        state == S_XTAL && next_state == S_RUN && ctrl[seq_pkg::CTRL_INDEP] ##1 state == S_RUN
        |=> step_b.cal_active)
        else $error("PLL B did not start with PLL A");

    a_rd_clear: assert property (@(posedge clk_i) disable iff (srst_i)
        acc && avs_read_i && avs_address_i == seq_pkg::REG_INT_STAT && events == '0
        |=> (int_stat & rdata[seq_pkg::INT_W-1:0]) == '0)
        else $error("status read did not clear returned bits");

    // Status bits stay set until a status read returns them
    a_stat_sticky: assert property (@(posedge clk_i) disable iff (srst_i)
        !(acc && avs_read_i && avs_address_i == seq_pkg::REG_INT_STAT)
        |=> (int_stat & $past(int_stat)) == $past(int_stat))
        else $error("status bit lost without a read");
endmodule : dual_pll_powerup_sequencer
`default_nettype wire

// File: verification/host_side_model.sv
// Host and analog side model: power-down pin, PLL lock and phase-detector ticks
`timescale 1ns/1ps
`default_nettype none
module host_side_model (
    input  wire logic clk_i,
    input  wire logic run_i,
    input  wire logic oe_a_i,
    input  wire logic oe_b_i,
    output logic      pdn_n_o,
    output logic      lock_a_o,
    output logic      lock_b_o,
    output logic      pfd_o
);
    // Host drives the pin on request; each loop locks a cycle after its outputs turn on
    always_ff @(posedge clk_i) begin
        pdn_n_o  <= run_i;
        lock_a_o <= oe_a_i;
        lock_b_o <= oe_b_i;
        pfd_o    <= run_i & !pfd_o;
    end
endmodule : host_side_model
`default_nettype wire

// File: verification/tb.sv
// Self-checking testbench for the dual PLL power-up sequencer
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        clk_i, srst_i, run, sup_ok, xtal_ok, rd, wr, pdn_n, lk_a, lk_b, pfd;
    logic        oe_a, oe_b, st_a, st_b, mgmt, irq, waitreq;
    logic [1:0]  cfg;
    logic [4:0]  adr;
    logic [31:0] wd, rdata, q;
    int          n_errors = 0;
    int          num_checks = 0;
    logic [4:0]  r_adr [5] = '{seq_pkg::REG_A_CAL, seq_pkg::REG_A_VCO, seq_pkg::REG_B_CAL,
                               seq_pkg::REG_B_VCO, seq_pkg::REG_INT_MASK};
    logic [31:0] r_val [5] = '{32'h0000_0002, 32'h0000_0002, 32'h0000_0002, 32'h0000_0002, 32'h0000_000F};
    wire  [4:0]  obs = {irq, st_b, st_a, oe_b, oe_a};
    dual_pll_powerup_sequencer #(.CNT_W(seq_pkg::CNT_W)) i_dut (.clk_i(clk_i), .srst_i(srst_i),
        .chip_power_down_n_i(pdn_n), .supply_ok_i(sup_ok), .cfg_pins_i(cfg), .crystal_ok_i(xtal_ok),
        .pll_a_lock_i(lk_a), .pll_b_lock_i(lk_b), .pfd_tick_a_i(pfd), .pfd_tick_b_i(pfd),
        .out_en_a_o(oe_a), .out_en_b_o(oe_b), .status_pin_a_o(st_a), .status_pin_b_o(st_b),
        .mgmt_bus_en_o(mgmt), .irq_o(irq), .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
        .avs_writedata_i(wd), .avs_byteenable_i(4'hF), .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq));
    host_side_model i_host (.clk_i(clk_i), .run_i(run), .oe_a_i(oe_a), .oe_b_i(oe_b),
        .pdn_n_o(pdn_n), .lock_a_o(lk_a), .lock_b_o(lk_b), .pfd_o(pfd));
    // Clock at 25 MHz
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    // Compare and report
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // One bus transfer, held until waitrequest is sampled low at a rising edge
    task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        rd  <= !w;
        wr  <= w;
        adr <= a;
        wd  <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (waitreq !== 1'b0 && n < 50);
        q = rdata;
        chk(n < 50, 1'b1);
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus
    // Bounded wait for one observed output to take a level
    task waitv(input int k, input logic v);
        int n;
        for (n = 0; n < 20000 && obs[k] !== v; n++) @(posedge clk_i);
        chk(obs[k], v);
    endtask : waitv
    // Verdict
    task finish_test;
        $display("checks=%0d errors=%0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : finish_test
    // Watchdog
    initial begin
        repeat (60000) @(posedge clk_i);
        n_errors++;
        finish_test();
    end
    // Main sequence
    initial begin
        srst_i = 1'b1;
        run = 1'b0;
        sup_ok = 1'b0;
        xtal_ok = 1'b0;
        cfg = 2'b01;
        rd = 1'b0;
        wr = 1'b0;
        adr = 5'h00;
        wd = 32'h0000_0000;
        repeat (10) @(posedge clk_i);
        srst_i <= 1'b0;
        @(posedge clk_i);
        chk({oe_a, oe_b, st_a, st_b, mgmt, irq}, 6'b001100);
        run <= 1'b1;
        sup_ok <= 1'b1;
        repeat (8) @(posedge clk_i);
        chk(mgmt, 1'b1);
        bus(1'b0, seq_pkg::REG_STATE, 0);
        chk(q[3:0], 4'h4);
        for (int i = 0; i < 5; i++) bus(1'b1, r_adr[i], r_val[i]);
        for (int i = 0; i < 5; i++) begin
            bus(1'b0, r_adr[i], 0);
            chk(q, r_val[i]);
        end
        $display("test setup done");
        xtal_ok <= 1'b1;
        waitv(0, 1'b1);
        chk(oe_b, 1'b0);
        waitv(2, 1'b0);
        waitv(1, 1'b1);
        waitv(3, 1'b0);
        waitv(4, 1'b1);
        bus(1'b0, seq_pkg::REG_INT_STAT, 0);
        chk(q[3:0] & 4'hB, 4'hB);
        bus(1'b0, seq_pkg::REG_INT_STAT, 0);
        chk(q[3:0] & 4'hB, 4'h0);
        $display("test sequential start done");
        run <= 1'b0;
        repeat (6) @(posedge clk_i);
        chk({oe_a, oe_b, mgmt, st_a, irq}, 5'b00011);
        cfg <= 2'b10;
        sup_ok <= 1'b0;
        run <= 1'b1;
        repeat (20) @(posedge clk_i);
        bus(1'b0, seq_pkg::REG_STATE, 0);
        chk(q[3:0], 4'h1);
        sup_ok <= 1'b1;
        waitv(0, 1'b1);
        chk(oe_b, 1'b1);
        $display("test independent start done");
        finish_test();
    end
endmodule : tb
`default_nettype wire
